// File: src/tmds_delay.sv
// package of shared constants and the down-counting delay timer
`default_nettype none

package tmds_pkg;
  // register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STAT = 12'h004;
  // control word fields
  localparam int CTL_CODE_LSB = 0;
  localparam int CTL_UNIT_LSB = 4;
  localparam int CTL_SLOW_BIT = 8;
  localparam int CTL_CLR_BIT = 31;
  // status word fields
  localparam int ST_DIR_LSB = 0;
  localparam int ST_BUSY_BIT = 4;
  localparam int ST_REFUSED_BIT = 5;
  localparam int ST_WMOTION_BIT = 6;
  localparam int ST_WCTRL_BIT = 7;
  localparam int ST_WTERM_BIT = 8;
  localparam int ST_READ_BIT = 9;
  localparam int ST_ACCEPT_BIT = 10;
  localparam int ST_RWND_LSB = 12;
  localparam int ST_READY_LSB = 16;
  localparam int ST_LDPT_LSB = 20;
  // directive function codes
  localparam logic [2:0] FC_NONE = 3'h0;
  localparam logic [2:0] FC_SKIP = 3'h1;
  localparam logic [2:0] FC_WFM = 3'h2;
  localparam logic [2:0] FC_SFWD = 3'h3;
  localparam logic [2:0] FC_SBWD = 3'h4;
  localparam logic [2:0] FC_BKSP = 3'h5;
  localparam logic [2:0] FC_RWND = 3'h6;
  // file mark frame and end-of-record gap
  localparam logic [5:0] FILE_MARK = 6'h0f;
  localparam logic [1:0] BLANK_FRAMES = 2'h3;
  // timing
  localparam int unsigned CLK_NS = 10;
  localparam int unsigned DLY_FAST_MS = 30;
  localparam int unsigned DLY_SLOW_MS = 70;
  localparam int unsigned FRAME_NS = 1000;
  localparam int unsigned RWND_PULSE_NS = 1000;
  localparam logic [23:0] DLY_FAST_CYC = 24'(DLY_FAST_MS * 1000000 / CLK_NS);
  localparam logic [23:0] DLY_SLOW_CYC = 24'(DLY_SLOW_MS * 1000000 / CLK_NS);
  localparam logic [23:0] FRAME_CYC = 24'((FRAME_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [23:0] RWND_PULSE_CYC = 24'((RWND_PULSE_NS + CLK_NS - 1) / CLK_NS);
  // sequencer states
  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_WDELAY = 8'h02,
    ST_WDATA = 8'h04,
    ST_WGAP = 8'h08,
    ST_WCHK = 8'h10,
    ST_WTERM = 8'h20,
    ST_READ = 8'h40,
    ST_RWND = 8'h80
  } tmds_state_e;
endpackage

module tmds_delay (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // load and expiry
  input wire logic load,
  input wire logic [23:0] load_val,
  output logic done
);
  logic [23:0] cnt_r;
  logic [23:0] cnt_nxt;
  logic done_r;
  logic done_nxt;

  ////////////////////////////////////////////////////////////////
  // count down to zero, flag expiry for one cycle
  always_comb begin
    cnt_nxt = cnt_r;
    done_nxt = 1'b0;
    if (load) begin
      cnt_nxt = load_val;
    end else if (cnt_r != 24'h000000) begin
      cnt_nxt = cnt_r - 24'h000001;
      done_nxt = (cnt_r == 24'h000001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 24'h000000;
      done_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      done_r <= done_nxt;
    end
  end

  assign done = done_r;
endmodule // tmds_delay

`default_nettype wire

// File: src/tmds_sync.sv
// two-flop synchroniser for handler status lines
`default_nettype none

module tmds_sync #(
  parameter int W = 9
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // asynchronous in, synchronised out
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta_r;
  logic [W-1:0] stable_r;

  ////////////////////////////////////////////////////////////////
  // first stage feeds only the second
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= '0;
      stable_r <= '0;
    end else begin
      meta_r <= async_in;
      stable_r <= meta_r;
    end
  end

  assign sync_out = stable_r;
endmodule // tmds_sync

`default_nettype wire

// File: src/tmds_top.sv
// tape motion directive sequencer with apb register access
`default_nettype none

module tmds_top #(
  parameter logic [23:0] DLY_FAST_CYC = tmds_pkg::DLY_FAST_CYC,
  parameter logic [23:0] DLY_SLOW_CYC = tmds_pkg::DLY_SLOW_CYC
) (
  // apb slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // tape handler status, asynchronous
  input wire logic [3:0] hnd_ready,
  input wire logic [3:0] hnd_load_point,
  input wire logic hnd_eor,
  // tape handler motion and mode
  output logic [1:0] hnd_unit,
  output logic hnd_forward,
  output logic hnd_reverse,
  output logic hnd_read,
  output logic hnd_write,
  output logic hnd_search,
  output logic hnd_rewind,
  // write frames toward the head
  output logic [5:0] wr_data,
  output logic wr_strobe
);
  ////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic is_reverse(input logic [2:0] code);
    is_reverse = (code == tmds_pkg::FC_SBWD) || (code == tmds_pkg::FC_BKSP);
  endfunction

  function automatic logic is_search(input logic [2:0] code);
    is_search = (code == tmds_pkg::FC_SFWD) || (code == tmds_pkg::FC_SBWD);
  endfunction

  ////////////////////////////////////////////////////////////////
  // declarations
  tmds_pkg::tmds_state_e state_r;
  tmds_pkg::tmds_state_e state_nxt;
  logic [2:0] dir_r, dir_nxt;
  logic [1:0] unit_r, unit_nxt;
  logic slow_r, slow_nxt;
  logic write_motion_r, write_motion_nxt;
  logic write_control_r, write_control_nxt;
  logic write_term1_r, write_term1_nxt;
  logic data_accepted_flag_r, data_accepted_flag_nxt;
  logic [5:0] first_write_register_r, first_write_register_nxt;
  logic read_flag_r, read_flag_nxt;
  logic [5:0] lrc_r, lrc_nxt;
  logic [1:0] blank_cnt_r, blank_cnt_nxt;
  logic [3:0] rewinding_r, rewinding_nxt;
  logic refused_r, refused_nxt;
  logic eor_d_r;
  logic [1:0] hnd_unit_r, hnd_unit_nxt;
  logic hnd_forward_r, hnd_forward_nxt;
  logic hnd_reverse_r, hnd_reverse_nxt;
  logic hnd_read_r, hnd_read_nxt;
  logic hnd_write_r, hnd_write_nxt;
  logic hnd_search_r, hnd_search_nxt;
  logic hnd_rewind_r, hnd_rewind_nxt;
  logic [5:0] wr_data_r, wr_data_nxt;
  logic wr_strobe_r, wr_strobe_nxt;
  logic [31:0] prdata_r, prdata_nxt;
  logic pready_r, pready_nxt;
  logic pslverr_r, pslverr_nxt;
  logic [8:0] hsync;
  logic [3:0] ready_s;
  logic [3:0] ldpt_s;
  logic eor_s;
  logic eor_rise;
  logic tmr_load;
  logic [23:0] tmr_val;
  logic tmr_done;
  logic ctrl_wr;
  logic [2:0] req_code;
  logic [1:0] req_unit;
  logic req_clear;
  logic req_ok;
  logic start_ok;
  logic [31:0] stat_word;

  ////////////////////////////////////////////////////////////////
  // submodules
  tmds_sync #(
    .W(9)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .async_in({hnd_eor, hnd_load_point, hnd_ready}),
    .sync_out(hsync)
  );

  tmds_delay u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done)
  );

  // synchronised handler lines and end-of-record edge
  assign ready_s = hsync[3:0];
  assign ldpt_s = hsync[7:4];
  assign eor_s = hsync[8];
  assign eor_rise = eor_s && !eor_d_r;

  ////////////////////////////////////////////////////////////////
  // control word decode
  assign ctrl_wr = psel && penable && pready_r && pwrite && (paddr == tmds_pkg::ADDR_CTRL);
  assign req_code = pwdata[tmds_pkg::CTL_CODE_LSB +: 3];
  assign req_unit = pwdata[tmds_pkg::CTL_UNIT_LSB +: 2];
  assign req_clear = pwdata[tmds_pkg::CTL_CLR_BIT];
  assign req_ok = ctrl_wr && !req_clear && (state_r == tmds_pkg::ST_IDLE) &&
                  (req_code != tmds_pkg::FC_NONE) && (req_code <= tmds_pkg::FC_RWND);
  assign start_ok = req_ok && !rewinding_r[req_unit];

  ////////////////////////////////////////////////////////////////
  // sequencer next state, flags and handler lines
  always_comb begin
    state_nxt = state_r;
    dir_nxt = dir_r;
    unit_nxt = unit_r;
    slow_nxt = slow_r;
    write_motion_nxt = write_motion_r;
    write_control_nxt = write_control_r;
    write_term1_nxt = write_term1_r;
    data_accepted_flag_nxt = data_accepted_flag_r;
    first_write_register_nxt = first_write_register_r;
    read_flag_nxt = read_flag_r;
    lrc_nxt = lrc_r;
    blank_cnt_nxt = blank_cnt_r;
    refused_nxt = refused_r;
    wr_data_nxt = wr_data_r;
    wr_strobe_nxt = 1'b0;
    tmr_load = 1'b0;
    tmr_val = tmds_pkg::FRAME_CYC;
    // ready and load point report frees the handler
    rewinding_nxt = rewinding_r & ~(ready_s & ldpt_s);
    if (ctrl_wr && req_clear) begin
      // master clear drops the active directive
      state_nxt = tmds_pkg::ST_IDLE;
      dir_nxt = tmds_pkg::FC_NONE;
      write_motion_nxt = 1'b0;
      write_control_nxt = 1'b0;
      write_term1_nxt = 1'b0;
      data_accepted_flag_nxt = 1'b0;
      read_flag_nxt = 1'b0;
      refused_nxt = 1'b0;
    end else if (req_ok && rewinding_r[req_unit]) begin
      refused_nxt = 1'b1;
    end else if (start_ok) begin
      // other handlers stay usable while one rewinds
      refused_nxt = 1'b0;
      dir_nxt = req_code;
      unit_nxt = req_unit;
      slow_nxt = pwdata[tmds_pkg::CTL_SLOW_BIT];
      lrc_nxt = 6'h00;
      blank_cnt_nxt = 2'h0;
      case (req_code)
        tmds_pkg::FC_SKIP, tmds_pkg::FC_WFM: begin
          write_motion_nxt = 1'b1;
          tmr_load = 1'b1;
          tmr_val = pwdata[tmds_pkg::CTL_SLOW_BIT] ? DLY_SLOW_CYC : DLY_FAST_CYC;
          state_nxt = tmds_pkg::ST_WDELAY;
        end
        tmds_pkg::FC_SFWD, tmds_pkg::FC_SBWD, tmds_pkg::FC_BKSP: begin
          read_flag_nxt = 1'b1;
          state_nxt = tmds_pkg::ST_READ;
        end
        tmds_pkg::FC_RWND: begin
          tmr_load = 1'b1;
          tmr_val = tmds_pkg::RWND_PULSE_CYC;
          state_nxt = tmds_pkg::ST_RWND;
        end
        default: begin
          state_nxt = tmds_pkg::ST_IDLE;
        end
      endcase
    end else begin
      case (state_r)
        tmds_pkg::ST_IDLE: begin
          state_nxt = tmds_pkg::ST_IDLE;
        end
        tmds_pkg::ST_WDELAY: begin
          if (tmr_done) begin
            write_control_nxt = 1'b1;
            if (dir_r == tmds_pkg::FC_WFM) begin
              data_accepted_flag_nxt = 1'b1;
              first_write_register_nxt = tmds_pkg::FILE_MARK;
              state_nxt = tmds_pkg::ST_WDATA;
            end else begin
              state_nxt = tmds_pkg::ST_WTERM;
            end
          end
        end
        tmds_pkg::ST_WDATA: begin
          // the one and only data frame
          wr_strobe_nxt = 1'b1;
          wr_data_nxt = first_write_register_r;
          lrc_nxt = lrc_r ^ first_write_register_r;
          data_accepted_flag_nxt = 1'b0;
          tmr_load = 1'b1;
          state_nxt = tmds_pkg::ST_WGAP;
        end
        tmds_pkg::ST_WGAP: begin
          if (tmr_done) begin
            blank_cnt_nxt = blank_cnt_r + 2'h1;
            if (blank_cnt_r + 2'h1 == tmds_pkg::BLANK_FRAMES) begin
              state_nxt = tmds_pkg::ST_WCHK;
            end else begin
              tmr_load = 1'b1;
            end
          end
        end
        tmds_pkg::ST_WCHK: begin
          // check character closes the record
          wr_strobe_nxt = 1'b1;
          wr_data_nxt = lrc_r;
          state_nxt = tmds_pkg::ST_WTERM;
        end
        tmds_pkg::ST_WTERM: begin
          if (!write_term1_r) begin
            write_term1_nxt = 1'b1;
            tmr_load = 1'b1;
          end else if (tmr_done) begin
            state_nxt = tmds_pkg::ST_IDLE;
            dir_nxt = tmds_pkg::FC_NONE;
            write_motion_nxt = 1'b0;
            write_control_nxt = 1'b0;
            write_term1_nxt = 1'b0;
          end
        end
        tmds_pkg::ST_READ: begin
          // search stretches only through handler filtering of end of record
          if (eor_rise) begin
            state_nxt = tmds_pkg::ST_IDLE;
            dir_nxt = tmds_pkg::FC_NONE;
            read_flag_nxt = 1'b0;
          end
        end
        tmds_pkg::ST_RWND: begin
          if (tmr_done) begin
            rewinding_nxt[unit_r] = 1'b1;
            state_nxt = tmds_pkg::ST_IDLE;
            dir_nxt = tmds_pkg::FC_NONE;
          end
        end
        default: begin
          state_nxt = tmds_pkg::ST_IDLE;
        end
      endcase
    end
    // handler lines follow the next flag and unit values, rewind the next state
    hnd_unit_nxt = unit_nxt;
    hnd_write_nxt = write_motion_nxt;
    hnd_read_nxt = read_flag_nxt;
    hnd_reverse_nxt = read_flag_nxt && is_reverse(dir_nxt);
    hnd_forward_nxt = write_motion_nxt || (read_flag_nxt && !is_reverse(dir_nxt));
    hnd_search_nxt = read_flag_nxt && is_search(dir_nxt);
    hnd_rewind_nxt = (state_nxt == tmds_pkg::ST_RWND);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= tmds_pkg::ST_IDLE;
      dir_r <= tmds_pkg::FC_NONE;
      unit_r <= 2'h0;
      slow_r <= 1'b0;
      write_motion_r <= 1'b0;
      write_control_r <= 1'b0;
      write_term1_r <= 1'b0;
      data_accepted_flag_r <= 1'b0;
      first_write_register_r <= 6'h00;
      read_flag_r <= 1'b0;
      lrc_r <= 6'h00;
      blank_cnt_r <= 2'h0;
      rewinding_r <= 4'h0;
      refused_r <= 1'b0;
      eor_d_r <= 1'b0;
      hnd_unit_r <= 2'h0;
      hnd_forward_r <= 1'b0;
      hnd_reverse_r <= 1'b0;
      hnd_read_r <= 1'b0;
      hnd_write_r <= 1'b0;
      hnd_search_r <= 1'b0;
      hnd_rewind_r <= 1'b0;
      wr_data_r <= 6'h00;
      wr_strobe_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      dir_r <= dir_nxt;
      unit_r <= unit_nxt;
      slow_r <= slow_nxt;
      write_motion_r <= write_motion_nxt;
      write_control_r <= write_control_nxt;
      write_term1_r <= write_term1_nxt;
      data_accepted_flag_r <= data_accepted_flag_nxt;
      first_write_register_r <= first_write_register_nxt;
      read_flag_r <= read_flag_nxt;
      lrc_r <= lrc_nxt;
      blank_cnt_r <= blank_cnt_nxt;
      rewinding_r <= rewinding_nxt;
      refused_r <= refused_nxt;
      eor_d_r <= eor_s;
      hnd_unit_r <= hnd_unit_nxt;
      hnd_forward_r <= hnd_forward_nxt;
      hnd_reverse_r <= hnd_reverse_nxt;
      hnd_read_r <= hnd_read_nxt;
      hnd_write_r <= hnd_write_nxt;
      hnd_search_r <= hnd_search_nxt;
      hnd_rewind_r <= hnd_rewind_nxt;
      wr_data_r <= wr_data_nxt;
      wr_strobe_r <= wr_strobe_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // status word assembly
  always_comb begin
    stat_word = 32'h00000000;
    stat_word[tmds_pkg::ST_DIR_LSB +: 3] = dir_r;
    stat_word[tmds_pkg::ST_BUSY_BIT] = (state_r != tmds_pkg::ST_IDLE);
    stat_word[tmds_pkg::ST_REFUSED_BIT] = refused_r;
    stat_word[tmds_pkg::ST_WMOTION_BIT] = write_motion_r;
    stat_word[tmds_pkg::ST_WCTRL_BIT] = write_control_r;
    stat_word[tmds_pkg::ST_WTERM_BIT] = write_term1_r;
    stat_word[tmds_pkg::ST_READ_BIT] = read_flag_r;
    stat_word[tmds_pkg::ST_ACCEPT_BIT] = data_accepted_flag_r;
    stat_word[tmds_pkg::ST_RWND_LSB +: 4] = rewinding_r;
    stat_word[tmds_pkg::ST_READY_LSB +: 4] = ready_s;
    stat_word[tmds_pkg::ST_LDPT_LSB +: 4] = ldpt_s;
  end

  ////////////////////////////////////////////////////////////////
  // apb answer: ready and data captured in the setup cycle
  always_comb begin
    pready_nxt = psel && !penable;
    pslverr_nxt = 1'b0;
    prdata_nxt = 32'h00000000;
    if (psel && !penable) begin
      if (paddr == tmds_pkg::ADDR_STAT) begin
        prdata_nxt = pwrite ? 32'h00000000 : stat_word;
      end else if (paddr == tmds_pkg::ADDR_CTRL) begin
        prdata_nxt = {29'h00000000, dir_r};
      end else begin
        pslverr_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= 32'h00000000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      prdata_r <= prdata_nxt;
      pready_r <= pready_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign hnd_unit = hnd_unit_r;
  assign hnd_forward = hnd_forward_r;
  assign hnd_reverse = hnd_reverse_r;
  assign hnd_read = hnd_read_r;
  assign hnd_write = hnd_write_r;
  assign hnd_search = hnd_search_r;
  assign hnd_rewind = hnd_rewind_r;
  assign wr_data = wr_data_r;
  assign wr_strobe = wr_strobe_r;

  ////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_fm_ctrl_up;
    $rose(write_control_r) && (dir_r == tmds_pkg::FC_WFM);
  endsequence

  sequence s_fm_frame_out;
    wr_strobe_r && (wr_data_r == tmds_pkg::FILE_MARK);
  endsequence

  AST_SKIP_MOTION: assert property (start_ok && req_code == tmds_pkg::FC_SKIP |=>
    write_motion_r && hnd_write_r && !read_flag_r) else $error("skip did not raise write motion");
  AST_WAIT_DELAY: assert property ($rose(write_motion_r) |-> !write_control_r [*8])
    else $error("write control set before delay");
  AST_TERM_FOLLOWS: assert property ($rose(write_control_r) && dir_r == tmds_pkg::FC_SKIP
    |=> write_term1_r) else $error("termination flag late");
  AST_FM_LOAD: assert property (s_fm_ctrl_up |-> data_accepted_flag_r &&
    first_write_register_r == tmds_pkg::FILE_MARK ##1 s_fm_frame_out) else $error("file mark not loaded");
  AST_THREE_BLANKS: assert property (wr_strobe_r && state_r == tmds_pkg::ST_WTERM |->
    blank_cnt_r == tmds_pkg::BLANK_FRAMES && wr_data_r == tmds_pkg::FILE_MARK) else $error("gap wrong");
  AST_FWD_SEARCH: assert property (read_flag_r && dir_r == tmds_pkg::FC_SFWD |->
    hnd_forward_r && hnd_read_r && hnd_search_r && !hnd_reverse_r) else $error("forward search lines");
  AST_BACK_SEARCH: assert property (read_flag_r && dir_r == tmds_pkg::FC_SBWD |->
    hnd_reverse_r && hnd_read_r && hnd_search_r && !hnd_forward_r) else $error("backward search lines");
  AST_BACKSPACE: assert property (read_flag_r && dir_r == tmds_pkg::FC_BKSP |->
    hnd_reverse_r && hnd_read_r && !hnd_search_r) else $error("backspace lines");
  AST_EOR_ENDS: assert property (state_r == tmds_pkg::ST_READ && eor_rise && !ctrl_wr |=>
    state_r == tmds_pkg::ST_IDLE && !hnd_read_r) else $error("end of record ignored");
  AST_REWIND_OUT: assert property (start_ok && req_code == tmds_pkg::FC_RWND |=>
    hnd_rewind_r && hnd_unit_r == $past(req_unit)) else $error("rewind not driven");
  AST_HOLD_REWINDING: assert property (req_ok && rewinding_r[req_unit] |=>
    refused_r && state_r == tmds_pkg::ST_IDLE) else $error("rewinding handler restarted");
  AST_ONE_ACTIVE: assert property (!(write_motion_r && read_flag_r))
    else $error("two directives active");
endmodule // tmds_top

`default_nettype wire

// File: tb/tmds_handler_model.sv
// behavioural tape handler facing the directive sequencer
`default_nettype none
module tmds_handler_model (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // motion and mode from the sequencer
  input wire logic [1:0] hnd_unit,
  input wire logic hnd_read,
  input wire logic hnd_search,
  input wire logic hnd_rewind,
  // status back to the sequencer
  output logic [3:0] hnd_ready,
  output logic [3:0] hnd_load_point,
  output logic hnd_eor
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] cnt;
  logic [15:0] rw_cnt;
  logic [1:0] rw_u;
  // a record gap passes at 12 clock cycles, a file mark lies at 40
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 16'h0;
      hnd_eor <= 1'b0;
      hnd_ready <= 4'hf;
      hnd_load_point <= 4'h0;
      rw_cnt <= 16'h0;
      rw_u <= 2'h0;
    end else begin
      cnt <= hnd_read ? cnt + 16'h1 : 16'h0;
      hnd_eor <= hnd_read && (hnd_eor || cnt == (hnd_search ? 16'h28 : 16'h0c));
      if (hnd_rewind && hnd_ready[hnd_unit]) begin
        hnd_ready[hnd_unit] <= 1'b0;
        hnd_load_point[hnd_unit] <= 1'b0;
        rw_u <= hnd_unit;
        rw_cnt <= 16'h190;
      end else if (rw_cnt != 16'h0) begin
        rw_cnt <= rw_cnt - 16'h1;
        hnd_ready[rw_u] <= (rw_cnt == 16'h1);
        hnd_load_point[rw_u] <= (rw_cnt == 16'h1);
      end
    end
  end
endmodule // tmds_handler_model
`default_nettype wire

// File: tb/tmds_top_bench.sv
// self-checking bench for the directive sequencer
`default_nettype none
module tmds_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic hnd_eor, hnd_forward, hnd_reverse, hnd_read, hnd_write, hnd_search, hnd_rewind, wr_strobe;
  logic [3:0] hnd_ready, hnd_load_point;
  logic [1:0] hnd_unit;
  logic [5:0] wr_data;
  int n_mismatch = 0, samples_checked = 0, cyc = 0, n_strb = 0, n_bad = 0, t_strb = 0, t_gap = 0, c;
  tmds_top #(.DLY_FAST_CYC(24'h14), .DLY_SLOW_CYC(24'h28)) i_dut (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .hnd_ready(hnd_ready), .hnd_load_point(hnd_load_point),
    .hnd_eor(hnd_eor), .hnd_unit(hnd_unit), .hnd_forward(hnd_forward), .hnd_reverse(hnd_reverse),
    .hnd_read(hnd_read), .hnd_write(hnd_write), .hnd_search(hnd_search), .hnd_rewind(hnd_rewind),
    .wr_data(wr_data), .wr_strobe(wr_strobe));
  tmds_handler_model i_hnd (.pclk(pclk), .presetn(presetn), .hnd_unit(hnd_unit), .hnd_read(hnd_read),
    .hnd_search(hnd_search), .hnd_rewind(hnd_rewind), .hnd_ready(hnd_ready),
    .hnd_load_point(hnd_load_point), .hnd_eor(hnd_eor));
  always #5 pclk = ~pclk;
  // frame strobe monitor
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (wr_strobe === 1'b1) begin
      n_strb <= n_strb + 1;
      n_bad <= n_bad + (wr_data !== 6'h0f);
      t_gap <= cyc - t_strb;
      t_strb <= cyc;
    end
  end
  //////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is seen at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin n_mismatch++; test_done; end
  endtask
  // count cycles until every motion line has dropped
  task automatic wait_op;
    @(posedge pclk);
    c = 1;
    do begin @(posedge pclk); c++; end while ((hnd_write | hnd_read | hnd_rewind) !== 1'b0 && c < 2000);
    if (c >= 2000) begin n_mismatch++; test_done; end
  endtask
  task automatic go(input logic [31:0] d);
    apb(1'b1, tmds_pkg::ADDR_CTRL, d);
    repeat (2) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////
  task automatic t_bus;
    apb(1'b0, 12'h008, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, err});
    apb(1'b0, tmds_pkg::ADDR_STAT, 32'h0);
    chk("status after reset", 32'h000f0000, rd);
    $display("bus test done");
  endtask
  task automatic t_write;
    go(32'h1);
    chk("skip motion", 32'h3, {hnd_write, hnd_forward});
    wait_op;
    chk("skip time", 32'h1, {31'h0, c > 20 && c < 200});
    chk("skip frames", 32'h0, n_strb);
    go(32'h102);
    wait_op;
    chk("mark frames", 32'h2, n_strb);
    chk("mark codes", 32'h0, n_bad);
    // each blank frame costs its timer plus one reload cycle, and the check character one more
    chk("mark gap", 32'(3 * (tmds_pkg::FRAME_CYC + 24'h1) + 24'h1), t_gap);
    chk("slow time", 32'h1, {31'h0, c > 440 && c < 600});
    $display("write test done");
  endtask
  task automatic t_read;
    logic [3:0] exp [3] = '{4'b1011, 4'b0111, 4'b0110};
    int lo;
    for (int i = 0; i < 3; i++) begin
      go(32'(i + 3));
      chk("lines", 32'(exp[i]), {hnd_forward, hnd_reverse, hnd_read, hnd_search});
      wait_op;
      lo = exp[i][0] ? 40 : 12;
      chk("read end", 32'h1, {31'h0, c > lo && c < lo + 12});
    end
    $display("read test done");
  endtask
  task automatic t_rewind;
    go(32'h16);
    chk("rewind line", 32'h5, {hnd_rewind, hnd_unit});
    wait_op;
    go(32'h15);
    apb(1'b0, tmds_pkg::ADDR_STAT, 32'h0);
    chk("refused", 32'h1, {31'h0, rd[5] & ~hnd_read});
    go(32'h25);
    chk("other unit", 32'h6, {hnd_read, hnd_unit});
    wait_op;
    c = 0;
    do begin apb(1'b0, tmds_pkg::ADDR_STAT, 32'h0); c++; end while (rd[13] !== 1'b0 && c < 300);
    if (rd[13] !== 1'b0) begin n_mismatch++; test_done; end
    go(32'h15);
    chk("after load point", 32'h5, {hnd_read, hnd_unit});
    wait_op;
    $display("rewind test done");
  endtask
  task automatic t_clear;
    go(32'h3);
    go(32'h1);
    chk("second directive", 32'h1, {hnd_write, hnd_read});
    go(32'h80000000);
    apb(1'b0, tmds_pkg::ADDR_STAT, 32'h0);
    chk("cleared", 32'h0, {hnd_read, rd[4:0]});
    $display("clear test done");
  endtask
  // reset, then the scenarios in turn
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_bus;
    t_write;
    t_read;
    t_rewind;
    t_clear;
    test_done;
  end
endmodule // tmds_top_bench
`default_nettype wire
